// [mfx_pkg.sv]
/*
 * Package for the instruction format decoder and multiply/xor execute block.
 * Holds field positions, opcode prefixes, quarter phase codes and carriers.
 * Assumes a 16-bit instruction word and an 8-bit data path.
 */
package mfx_pkg;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int DEST_BIT     = 9;
	localparam int ACCESS_BIT   = 8;
	localparam int FADDR_MSB    = 7;
	localparam int BITSEL_LSB   = 9;
	localparam int LIT_MSB      = 7;
	localparam int BRA_OFS_MSB  = 10;
	localparam int CALL_FAST    = 8;
	localparam int MOVE_ADR_MSB = 11;

	// ************************************************************
	// Opcode prefixes and second word mark
	// ************************************************************
	localparam logic [7:0] OPC_MUL_LIT  = 8'h0D;
	localparam logic [6:0] OPC_MUL_FILE = 7'h01;
	localparam logic [5:0] OPC_XOR      = 6'h06;
	localparam logic [3:0] OPC_MOVE     = 4'hC;
	localparam logic [3:0] SECOND_WORD  = 4'hF;
	localparam logic [7:0] OPC_GOTO     = 8'hEF;
	localparam logic [6:0] OPC_CALL     = 7'h76;
	localparam logic [4:0] OPC_BRA      = 5'h1A;
	localparam logic [4:0] OPC_BCOND    = 5'h1C;

	// ************************************************************
	// Reset values and banking
	// ************************************************************
	localparam logic [7:0] ACCUM_RST    = 8'h00;
	localparam logic [3:0] BANK_RST     = 4'h0;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_HIGH  = 4'hF;

	// Quarter phases of one instruction cycle, one-hot
	typedef enum logic [3:0] {
		MFX_Q1 = 4'h1,
		MFX_Q2 = 4'h2,
		MFX_Q3 = 4'h4,
		MFX_Q4 = 4'h8
	} mfx_phase_t;

	// Decoded instruction fields
	typedef struct packed {
		logic        dest_file;
		logic        use_bank;
		logic [7:0]  faddr;
		logic [2:0]  bit_sel;
		logic [7:0]  literal;
		logic [10:0] bra_ofs;
		logic [7:0]  bcond_ofs;
		logic        fast;
	} mfx_fields_t;

	// Status flags seen by this block
	typedef struct packed {
		logic neg;
		logic zero;
	} mfx_flags_t;
endpackage : mfx_pkg

// [mfx_field_dec.sv]
/*
 * Field extractor for one 16-bit instruction word.
 * Assumes the word is stable from the fetch register; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module mfx_field_dec
	import mfx_pkg::*;
(
	// Instruction word
	input  wire logic [15:0] word,
	// Split fields
	output var mfx_fields_t  fields
);
	// ************************************************************
	// Field split
	// ************************************************************
	// All layouts share low bits, so each field is cut once
	always_comb begin
		fields.dest_file = word[DEST_BIT];
		fields.use_bank  = word[ACCESS_BIT];
		fields.faddr     = word[FADDR_MSB:0];
		fields.bit_sel   = word[BITSEL_LSB+2:BITSEL_LSB];
		fields.literal   = word[LIT_MSB:0];
		fields.bra_ofs   = word[BRA_OFS_MSB:0];
		fields.bcond_ofs = word[7:0];
		fields.fast      = word[CALL_FAST];
	end
endmodule : mfx_field_dec
`default_nettype wire

// [mfx_core.sv]
/*
 * Decode and execute for the core instruction formats, with the multiply
 * and exclusive-OR instructions carried out. Other opcodes are decoded
 * into fields and flags only. Assumes a file register memory that answers
 * a read address combinationally and takes a write strobe on clk.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Byte ops: destination bit 9, access bit 8, address bits 7..0.
// - Destination zero writes accumulator, one writes the file register.
// - Access bit zero uses access bank, one uses bank pointer.
// - Eight bit file address joined with bank to form full address.
// - Two word move: 12-bit source, second word 1111 plus destination.
// - Bit ops carry three bit position, access bit and file address.
// - Literal ops hold immediate in bits 7..0, opcode above.
// - Jump and call: two words, twenty bit target, second nibble 1111.
// - Call first word fast bit passed to call context logic.
// - Relative jump has eleven bit offset in bits 10..0.
// - Conditional branch has eight bit offset in bits 7..0.
// - Multiplies are unsigned 8x8 of accumulator with literal or file.
// - Product high and low bytes go to product pair; sources unchanged.
// - Multiplies change no status flag, even for zero product.
// - Exclusive-OR updates only negative and zero flags.
module mfx_core
	import mfx_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Instruction fetch
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	// File register memory
	output logic      [11:0] file_addr,
	input  wire logic [7:0]  file_rdata,
	output logic             file_we,
	output logic      [11:0] file_waddr,
	output logic      [7:0]  file_wdata,
	// Bank pointer from the core
	input  wire logic [3:0]  bank_select_pointer,
	// Architectural state
	output logic      [7:0]  working_accumulator,
	output logic      [7:0]  product_high_byte,
	output logic      [7:0]  product_low_byte,
	output var mfx_flags_t   flags,
	output logic             flags_we,
	// Decoded control words
	output logic      [11:0] move_src,
	output logic      [11:0] move_dst,
	output logic             move_done,
	output logic      [19:0] jump_target,
	output logic             jump_done,
	output logic             call_fast,
	output logic      [10:0] rel_offset,
	output logic      [7:0]  cond_offset,
	output logic      [2:0]  bit_position,
	output logic             cycle_done
);
	// ************************************************************
	// Field decode
	// ************************************************************
	mfx_fields_t fld;

	mfx_field_dec u_dec (
		.word   (instr_word),
		.fields (fld)
	);

	// ************************************************************
	// Opcode classes
	// ************************************************************
	logic is_mul_lit;
	logic is_mul_file;
	logic is_xor;
	logic is_move;
	logic is_goto;
	logic is_call;
	logic is_second;

	// Prefix matches on the upper bits of the word
	always_comb begin
		is_mul_lit  = instr_word[15:8] == OPC_MUL_LIT;
		is_mul_file = instr_word[15:9] == OPC_MUL_FILE;
		is_xor      = instr_word[15:10] == OPC_XOR;
		is_move     = instr_word[15:12] == OPC_MOVE;
		is_goto     = instr_word[15:8] == OPC_GOTO;
		is_call     = instr_word[15:9] == OPC_CALL;
		is_second   = instr_word[15:12] == SECOND_WORD;
	end

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [2:0] {
		MFX_W1 = 3'h1,
		MFX_MV = 3'h2,
		MFX_JP = 3'h4
	} mfx_word_t;

	mfx_phase_t  ph_r, ph_nxt;
	mfx_word_t   wd_r, wd_nxt;
	logic [7:0]  acc_r, acc_nxt;
	logic [7:0]  ph_hi_r, ph_hi_nxt;
	logic [7:0]  pl_lo_r, pl_lo_nxt;
	mfx_flags_t  flg_r, flg_nxt;
	logic        flg_we_r, flg_we_nxt;
	logic [15:0] ir_r, ir_nxt;
	logic [7:0]  opnd_r, opnd_nxt;
	logic [15:0] res_r, res_nxt;
	logic [11:0] msrc_r, msrc_nxt, mdst_r, mdst_nxt;
	logic [19:0] jt_r, jt_nxt;
	logic        mdone_r, mdone_nxt, jdone_r, jdone_nxt, fast_r, fast_nxt;
	logic [11:0] opaddr;
	logic        we_nxt;
	logic [7:0]  wdata_nxt;
	logic        we_r;
	logic [7:0]  wdata_r;
	logic [11:0] waddr_r, waddr_nxt;

	// Full operand address from latched word; access bank splits at 0x80
	always_comb begin
		if (ir_r[ACCESS_BIT])
			opaddr = {bank_select_pointer, ir_r[FADDR_MSB:0]};
		else if (ir_r[FADDR_MSB:0] < ACCESS_SPLIT)
			opaddr = {BANK_RST, ir_r[FADDR_MSB:0]};
		else
			opaddr = {ACCESS_HIGH, ir_r[FADDR_MSB:0]};
	end

	// ************************************************************
	// Next state: Q1 decode, Q2 read, Q3 process, Q4 write
	// ************************************************************
	always_comb begin
		ph_nxt     = ph_r;
		wd_nxt     = wd_r;
		acc_nxt    = acc_r;
		ph_hi_nxt  = ph_hi_r;
		pl_lo_nxt  = pl_lo_r;
		flg_nxt    = flg_r;
		flg_we_nxt = 1'b0;
		ir_nxt     = ir_r;
		opnd_nxt   = opnd_r;
		res_nxt    = res_r;
		msrc_nxt   = msrc_r;
		mdst_nxt   = mdst_r;
		jt_nxt     = jt_r;
		mdone_nxt  = 1'b0;
		jdone_nxt  = 1'b0;
		fast_nxt   = fast_r;
		we_nxt     = 1'b0;
		wdata_nxt  = wdata_r;
		waddr_nxt  = waddr_r;
		case (ph_r)
			MFX_Q1: begin
				// Decode: latch the word, wait while fetch stalls
				if (instr_valid) begin
					ir_nxt = instr_word;
					ph_nxt = MFX_Q2;
					case (wd_r)
						MFX_W1: begin
							if (is_move) begin
								msrc_nxt = instr_word[MOVE_ADR_MSB:0];
								wd_nxt   = MFX_MV;
							end else if (is_goto || is_call) begin
								jt_nxt[7:0] = instr_word[7:0];
								fast_nxt    = is_call & fld.fast;
								wd_nxt      = MFX_JP;
							end
						end
						MFX_MV: begin
							// A stray word without the mark drops the pair and is then executed as a single word
							if (is_second) begin
								mdst_nxt  = instr_word[MOVE_ADR_MSB:0];
								mdone_nxt = 1'b1;
							end
							wd_nxt = MFX_W1;
						end
						MFX_JP: begin
							if (is_second) begin
								jt_nxt[19:8] = instr_word[11:0];
								jdone_nxt    = 1'b1;
							end
							wd_nxt = MFX_W1;
						end
						default: wd_nxt = MFX_W1;
					endcase
				end
			end
			MFX_Q2: begin
				// Read operand: literal or file register
				opnd_nxt = (ir_r[15:8] == OPC_MUL_LIT) ? ir_r[LIT_MSB:0] : file_rdata;
				ph_nxt   = MFX_Q3;
			end
			MFX_Q3: begin
				// Process: unsigned 8x8 product or XOR
				if (wd_r == MFX_W1 && ir_r[15:10] == OPC_XOR)
					res_nxt = {8'h00, acc_r ^ opnd_r};
				else
					res_nxt = 16'(acc_r) * 16'(opnd_r);
				ph_nxt = MFX_Q4;
			end
			MFX_Q4: begin
				// Write only for words of the first kind
				if (wd_r == MFX_W1) begin
					if (ir_r[15:8] == OPC_MUL_LIT || ir_r[15:9] == OPC_MUL_FILE) begin
						ph_hi_nxt = res_r[15:8];
						pl_lo_nxt = res_r[7:0];
					end else if (ir_r[15:10] == OPC_XOR) begin
						flg_nxt.neg  = res_r[7];
						flg_nxt.zero = res_r[7:0] == 8'h00;
						flg_we_nxt   = 1'b1;
						if (ir_r[DEST_BIT]) begin
							we_nxt    = 1'b1;
							waddr_nxt = opaddr;
							wdata_nxt = res_r[7:0];
						end else
							acc_nxt = res_r[7:0];
					end
				end
				ph_nxt = MFX_Q1;
			end
			default: ph_nxt = MFX_Q1;
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ph_r <= MFX_Q1;  wd_r <= MFX_W1;
			acc_r <= ACCUM_RST;  ph_hi_r <= 8'h00;  pl_lo_r <= 8'h00;
			flg_r <= '0;  flg_we_r <= 1'b0;  ir_r <= 16'h0000;
			opnd_r <= 8'h00;  res_r <= 16'h0000;
			msrc_r <= 12'h000;  mdst_r <= 12'h000;  jt_r <= 20'h00000;
			mdone_r <= 1'b0;  jdone_r <= 1'b0;  fast_r <= 1'b0;
			we_r <= 1'b0;  wdata_r <= 8'h00;  waddr_r <= 12'h000;
		end else begin
			ph_r <= ph_nxt;  wd_r <= wd_nxt;
			acc_r <= acc_nxt;  ph_hi_r <= ph_hi_nxt;  pl_lo_r <= pl_lo_nxt;
			flg_r <= flg_nxt;  flg_we_r <= flg_we_nxt;  ir_r <= ir_nxt;
			opnd_r <= opnd_nxt;  res_r <= res_nxt;
			msrc_r <= msrc_nxt;  mdst_r <= mdst_nxt;  jt_r <= jt_nxt;
			mdone_r <= mdone_nxt;  jdone_r <= jdone_nxt;  fast_r <= fast_nxt;
			we_r <= we_nxt;  wdata_r <= wdata_nxt;  waddr_r <= waddr_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Fields of the latched word are held for the whole cycle
	mfx_fields_t ir_fld;
	mfx_field_dec u_dec_ir (
		.word   (ir_r),
		.fields (ir_fld)
	);

	assign file_addr           = opaddr;
	assign file_we             = we_r;
	assign file_waddr          = waddr_r;
	assign file_wdata          = wdata_r;
	assign working_accumulator = acc_r;
	assign product_high_byte   = ph_hi_r;
	assign product_low_byte    = pl_lo_r;
	assign flags               = flg_r;
	assign flags_we            = flg_we_r;
	assign move_src            = msrc_r;
	assign move_dst            = mdst_r;
	assign move_done           = mdone_r;
	assign jump_target         = jt_r;
	assign jump_done           = jdone_r;
	assign call_fast           = fast_r;
	assign rel_offset          = ir_fld.bra_ofs;
	assign cond_offset         = ir_fld.bcond_ofs;
	assign bit_position        = ir_fld.bit_sel;
	assign cycle_done          = ph_r == MFX_Q4;

	// ************************************************************
	// Checks
	// ************************************************************
	a_mul_product: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q4 && wd_r == MFX_W1 && ir_r[15:8] == OPC_MUL_LIT)
		|=> ({product_high_byte, product_low_byte} ==
			16'($past(acc_r)) * 16'($past(ir_r[7:0]))))
		else $error("product pair wrong after literal multiply");
	a_mul_noflags: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q4 && ir_r[15:9] == OPC_MUL_FILE) |=> $stable(flg_r) && !flags_we)
		else $error("multiply touched flags");
	a_mul_accum: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q4 && ir_r[15:8] == OPC_MUL_LIT) |=> $stable(acc_r) && !file_we)
		else $error("multiply changed a source");
	a_xor_dest_acc: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q4 && wd_r == MFX_W1 && ir_r[15:10] == OPC_XOR && !ir_r[DEST_BIT])
		|=> acc_r == $past(res_r[7:0]) && !file_we)
		else $error("xor result not in accumulator");
	a_xor_dest_file: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q4 && wd_r == MFX_W1 && ir_r[15:10] == OPC_XOR && ir_r[DEST_BIT])
		|=> file_we && file_wdata == $past(res_r[7:0]) && $stable(acc_r))
		else $error("xor result not written to file");
	a_xor_zero: assert property (@(posedge clk) disable iff (rst)
		flags_we |-> flags.zero == (file_we ? file_wdata == 8'h00 : acc_r == 8'h00))
		else $error("xor zero flag wrong");
	a_phase_cycle: assert property (@(posedge clk) disable iff (rst)
		(ph_r == MFX_Q2) |=> ph_r == MFX_Q3 ##1 ph_r == MFX_Q4 ##1 ph_r == MFX_Q1)
		else $error("quarter phases out of order");
	a_bank_addr: assert property (@(posedge clk) disable iff (rst)
		ir_r[ACCESS_BIT] |-> file_addr == {bank_select_pointer, ir_r[7:0]})
		else $error("bank pointer not used");
	a_move_pair: assert property (@(posedge clk) disable iff (rst)
		move_done |-> $past(wd_r) == MFX_MV && $past(instr_word[15:12]) == SECOND_WORD)
		else $error("move completed without second word");
	a_jump_pair: assert property (@(posedge clk) disable iff (rst)
		jump_done |-> jump_target[19:8] == $past(instr_word[11:0]))
		else $error("jump target high bits wrong");
endmodule : mfx_core
`default_nettype wire

// [test_mcu_instr_format_mul_xor.sv]
/*
 * Self-checking bench for mfx_core: drives instruction words, acts as the
 * file memory, keeps a reference model and compares each finished word.
 * Assumes a single 200 MHz clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instr_format_mul_xor;
	import mfx_pkg::*;
	// Expected state after one instruction word
	typedef struct packed {
		logic [7:0]  acc;
		logic [15:0] prod;
		mfx_flags_t  flg;
		logic        we;
		logic [11:0] wa;
		logic [7:0]  wd;
		logic [2:0]  kind;
		logic [23:0] dec;
	} mfx_exp_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [15:0] instr_word;
	logic [3:0]  bank_select_pointer;
	logic [11:0] file_addr, file_waddr, move_src, move_dst;
	logic [7:0]  file_rdata, file_wdata, working_accumulator, product_high_byte;
	logic [7:0]  product_low_byte, cond_offset;
	logic        file_we, call_fast, cycle_done, done_q;
	logic        flags_we, move_done, jump_done;
	logic [1:0]  pulse_q;
	mfx_flags_t  flags, m_flg;
	logic [19:0] jump_target, t;
	logic [10:0] rel_offset;
	logic [2:0]  bit_position;
	logic [7:0]  mem [4096];
	logic [7:0]  ref_mem [4096];
	logic [7:0]  m_acc;
	logic [15:0] m_prod;
	logic [11:0] src;
	mfx_exp_t    exp_q[$];
	mfx_exp_t    e;
	int          mismatches = 0;
	int          n_checks = 0;
	int          i;

	mfx_core mfx_core_inst (.clk, .rst, .instr_word, .instr_valid, .file_addr, .file_rdata,
		.file_we, .file_waddr, .file_wdata, .bank_select_pointer, .working_accumulator,
		.product_high_byte, .product_low_byte, .flags, .flags_we, .move_src, .move_dst,
		.move_done, .jump_target, .jump_done, .call_fast, .rel_offset, .cond_offset,
		.bit_position, .cycle_done);

	// ************************************************************
	// Clock and file memory
	// ************************************************************
	always #2.5 clk = ~clk;
	// Combinational read, write taken on the clock
	assign file_rdata = mem[file_addr];
	always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;

	// ************************************************************
	// Checking helpers
	// ************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
		n_checks++;
		if (got !== want) begin
			mismatches++;
			$display("[FAIL] %0t %s got %0h want %0h", $time, what, got, want);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// Snapshot of the model with the write and decode expectations
	function automatic mfx_exp_t mk(logic we, logic [11:0] wa, logic [7:0] wd,
		logic [2:0] kind, logic [23:0] dec);
		mk = '{m_acc, m_prod, m_flg, we, wa, wd, kind, dec};
	endfunction : mk

	// One word per instruction cycle, valid only for its taking edge
	task automatic issue(input logic [15:0] w, input logic [3:0] b, input mfx_exp_t x);
		@(posedge clk);
		instr_word          <= w;
		instr_valid         <= 1'b1;
		bank_select_pointer <= b;
		exp_q.push_back(x);
		@(posedge clk);
		instr_valid <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(cycle_done, 1'b1, "fourth quarter"); // Done in one cycle
	endtask : issue

	// Multiply literal (0), multiply file (1) or exclusive-OR (2, 3)
	task automatic alu(input logic [1:0] op, input logic d, input logic a,
		input logic [7:0] v, input logic [3:0] b);
		logic [11:0] ad;
		logic [7:0]  r;
		ad = a ? {b, v} : {(v < 8'h80) ? 4'h0 : 4'hF, v}; // Banking
		if (op == 2'd0) begin
			m_prod = m_acc * v; // Unsigned product
			issue({8'h0D, v}, b, mk(1'b0, 12'h000, 8'h00, 3'd0, 24'h0));
		end else if (op == 2'd1) begin
			m_prod = m_acc * ref_mem[ad]; // Unsigned product
			issue({7'h01, a, v}, b, mk(1'b0, 12'h000, 8'h00, 3'd0, 24'h0));
		end else begin
			r = m_acc ^ ref_mem[ad];
			m_flg = '{r[7], r == 8'h00}; // Negative and zero only
			if (d)
				ref_mem[ad] = r;
			else
				m_acc = r; // Destination choice
			issue({6'h06, d, a, v}, b, mk(d, ad, r, 3'd0, 24'h1)); // Flag strobe due
		end
	endtask : alu

	// Decode-only word with its expected field view
	task automatic word(input logic [15:0] w, input logic [2:0] kind, input logic [23:0] dec);
		issue(w, 4'h0, mk(1'b0, 12'h000, 8'h00, kind, dec));
	endtask : word

	// ************************************************************
	// Monitor: compare oldest note when a cycle completes
	// ************************************************************
	always @(negedge clk) begin
		// Pair pulses last one clock, so they are gathered until the compare
		pulse_q = pulse_q | {move_done, jump_done};
		if (!rst && done_q && !cycle_done) begin
			if (exp_q.size() == 0) begin
				check(1, 0, "unexpected result");
			end else begin
				e = exp_q.pop_front();
				check(working_accumulator, e.acc, "accum"); // Accum
				check({product_high_byte, product_low_byte}, e.prod, "product"); // Pair
				check(flags, e.flg, "flags"); // Flag effect
				check(file_we, e.we, "write strobe"); // File write
				if (e.we)
					check({file_waddr, file_wdata}, {e.wa, e.wd}, "write"); // Addr
				case (e.kind)
				3'd1: check({move_src, move_dst}, e.dec, "move"); // Move words
				3'd2, 3'd6: check(jump_target, e.dec[23:4], "target"); // Target
				3'd3: check(rel_offset, e.dec[10:0], "rel"); // Long offset
				3'd4: check(cond_offset, e.dec[7:0], "cond"); // Short offset
				3'd5: check(bit_position, e.dec[2:0], "bit"); // Bit field
				default: check(flags_we, e.dec[0], "flag strobe"); // Strobe
				endcase
				check(pulse_q, {e.kind == 3'd1, e.kind inside {3'd2, 3'd6}}, "pair");
				pulse_q = 2'b00;
				if (e.kind == 3'd6)
					check(call_fast, e.dec[3], "fast"); // Fast bit
			end
		end
		done_q = cycle_done;
	end

	// Watchdog sized well above the expected run
	initial begin
		#50000;
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		instr_word = 16'h0000;
		bank_select_pointer = 4'h0;
		done_q = 1'b0;
		pulse_q = 2'b00;
		m_acc = 8'h00;
		m_prod = 16'h0000;
		m_flg = '{1'b0, 1'b0};
		void'($urandom(90364));
		for (i = 0; i < 4096; i++) begin
			mem[i] = 8'($urandom);
			ref_mem[i] = mem[i];
		end
		mem[16] = 8'hE2;
		ref_mem[16] = 8'hE2;
		mem[12'hF90] = 8'hE2;
		ref_mem[12'hF90] = 8'hE2;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// Directed: load, multiply, zero product keeps flags, zero xor result
		alu(2'd2, 1'b0, 1'b0, 8'h10, 4'h0);
		alu(2'd0, 1'b0, 1'b0, 8'hC4, 4'h0);
		alu(2'd0, 1'b0, 1'b0, 8'h00, 4'h0);
		alu(2'd2, 1'b1, 1'b0, 8'h90, 4'h0);
		alu(2'd1, 1'b0, 1'b0, 8'h90, 4'h0);
		alu(2'd2, 1'b1, 1'b1, 8'h33, 4'h5);
		alu(2'd1, 1'b0, 1'b1, 8'h33, 4'h5);
		$display("test directed done");
		// Random mix, back to back
		for (i = 0; i < 30; i++)
			alu(2'($urandom), 1'($urandom), 1'($urandom), 8'($urandom), 4'($urandom));
		$display("test random done");
		// Two-word and single-word control layouts
		src = 12'($urandom);
		t = 20'($urandom);
		word({4'hC, src}, 3'd0, 24'h0);
		word({4'hF, t[11:0]}, 3'd1, {src, t[11:0]});
		// Move first word then an unmarked word: the pair is dropped
		word({4'hC, src}, 3'd0, 24'h0);
		word({4'h8, 3'd5, 1'b0, 8'h20}, 3'd5, {21'h0, 3'd5});
		word({8'hEF, t[7:0]}, 3'd0, 24'h0);
		word({4'hF, t[19:8]}, 3'd2, {t, 4'h0});
		for (i = 0; i < 2; i++) begin
			word({7'h76, 1'(i), t[7:0]}, 3'd0, 24'h0);
			word({4'hF, t[19:8]}, 3'd6, {t, 1'(i), 3'h0});
		end
		word({5'h1A, t[10:0]}, 3'd3, {13'h0, t[10:0]});
		word({8'hE2, t[7:0]}, 3'd4, {16'h0, t[7:0]});
		for (i = 0; i < 8; i++)
			word({4'h8, 3'(i), 1'b0, 8'h20}, 3'd5, {21'h0, 3'(i)});
		$display("test decode done");
		repeat (3) @(posedge clk);
		check(exp_q.size(), 0, "pending results");
		report_and_stop();
	end
endmodule : test_mcu_instr_format_mul_xor
`default_nettype wire
